// ### include/axs_defines.svh
// Constants for the two-axis positioning I/O block: map, fields, reset values
`ifndef AXS_DEFINES_SVH
`define AXS_DEFINES_SVH

`define AXS_N 2
`define AXS_AW 6
`define AXS_DW 16
`define AXS_PINS_W 6
`define AXS_CFG_W 8
`define AXS_EVT_W 4
`define AXS_IRQ_W 8
`define AXS_STRIDE 16

`define AXS_OFF_CFG 6'h00
`define AXS_OFF_CMD 6'h01
`define AXS_OFF_CNT 6'h02
`define AXS_OFF_HALF 6'h03
`define AXS_OFF_STAT 6'h04
`define AXS_IRQ_STAT 6'h20
`define AXS_IRQ_CLR 6'h21
`define AXS_IRQ_EN 6'h22

`define AXS_CMD_OPR 0
`define AXS_CMD_POS 1
`define AXS_CMD_SPD 2
`define AXS_CMD_DIR 3
`define AXS_CMD_STOP 4

`define AXS_ST_BUSY 0
`define AXS_ST_DONE 1
`define AXS_ST_REQ 2
`define AXS_ST_RDY_ERR 3
`define AXS_ST_LIM_ERR 4
`define AXS_ST_STATE 5
`define AXS_ST_STATE_W 3
`define AXS_ST_PINS 8

`define AXS_EVT_OPR 0
`define AXS_EVT_RDY 1
`define AXS_EVT_LIM 2
`define AXS_EVT_POS 3

`define AXS_CFG_RST 8'h00
`define AXS_CNT_RST 16'h0000
`define AXS_HALF_RST 16'h0032
`define AXS_ONE 16'h0001

`endif

// ### include/axs_pkg.sv
// Types shared by the positioning I/O block
package axs_pkg;

  typedef enum logic [1:0] {PM_CW_CCW, PM_PULSE_SIGN, PM_AB_X1, PM_AB_X4} axs_pmode_e;

  typedef enum logic [1:0] {OM_DOG, OM_STOPPER, OM_COUNT1, OM_COUNT2} axs_omethod_e;

  typedef enum logic [2:0] {ST_IDLE, ST_POS, ST_SPD, ST_DOG, ST_ZERO} axs_state_e;

  typedef struct packed {
    logic retry_en;
    logic llim_sel;
    logic ulim_sel;
    logic ready_sel;
    axs_omethod_e method;
    axs_pmode_e mode;
  } axs_cfg_s;

  typedef struct packed {
    logic origin_zero_input;
    logic speed_to_position_switch_input;
    logic drive_ready_input;
    logic near_point_input;
    logic upper_stroke_limit_input;
    logic lower_stroke_limit_input;
  } axs_pins_s;

endpackage

// ### rtl/axs_in_sync.sv
// Two-stage input synchroniser with leading-edge detection
`timescale 1ns/10ps
`default_nettype none

module axs_in_sync #(
  parameter int W = 12
) (
  input wire logic sys_clk_in,
  input wire logic reset_n_in,
  input wire logic [W-1:0] raw_in,
  output logic [W-1:0] lvl_out,
  output logic [W-1:0] rise_out
);

  logic [W-1:0] s1_q;
  logic [W-1:0] s2_q;
  logic [W-1:0] prev_q;

  always_ff @(posedge sys_clk_in)
  begin
    if (!reset_n_in)
    begin
      s1_q <= '0;
      s2_q <= '0;
      prev_q <= '0;
    end
    else
    begin
      s1_q <= raw_in;
      s2_q <= s1_q;
      prev_q <= s2_q;
    end
  end

  assign lvl_out = s2_q;
  assign rise_out = s2_q & ~prev_q;

endmodule

`default_nettype wire

// ### rtl/axs_pulse_gen.sv
// Pulse train encoder for one axis: CW/CCW, PULSE/SIGN, A/B x1 and x4
`timescale 1ns/10ps
`default_nettype none
`include "axs_defines.svh"

module axs_pulse_gen
  import axs_pkg::*;
(
  input wire logic sys_clk_in,
  input wire logic reset_n_in,
  input wire logic run_in,
  input wire logic dir_in,
  input wire axs_pkg::axs_pmode_e mode_in,
  input wire logic [`AXS_DW-1:0] half_in,
  output logic fwd_out,
  output logic rev_out,
  output logic step_out
);

  logic [`AXS_DW-1:0] div_q;
  logic [1:0] quad_q;
  logic [1:0] sub_q;
  logic ph_q;
  logic tick;
  logic [1:0] quad_d;

  // Index of the last half-period tick that closes one pulse
  function automatic logic [1:0] last_sub(input axs_pmode_e m);
    case (m)
      PM_AB_X1: last_sub = 2'h3;
      PM_AB_X4: last_sub = 2'h0;
      default: last_sub = 2'h1;
    endcase
  endfunction

  // A half period of zero is taken as one cycle
  assign tick = run_in && (({1'b0, div_q} + 17'h00001) >= {1'b0, half_in});
  assign quad_d = dir_in ? quad_q + 2'h1 : quad_q - 2'h1;
  // Step marks the tick that closes a pulse, so the axis stops on that same edge
  // and no extra half period leaks out when the half period is one cycle
  assign step_out = tick && (sub_q == last_sub(mode_in));

  always_ff @(posedge sys_clk_in)
  begin
    if (!reset_n_in || !run_in || tick)
      div_q <= '0;
    else
      div_q <= div_q + `AXS_ONE;
  end

  always_ff @(posedge sys_clk_in)
  begin
    if (!reset_n_in)
    begin
      ph_q <= 1'b0;
      sub_q <= 2'h0;
      quad_q <= 2'h0;
    end
    else
    begin
      if (!run_in)
      begin
        ph_q <= 1'b0;
        sub_q <= 2'h0;
      end
      else if (tick)
      begin
        ph_q <= ~ph_q;
        quad_q <= quad_d;
        if (sub_q == last_sub(mode_in))
          sub_q <= 2'h0;
        else
          sub_q <= sub_q + 2'h1;
      end
    end
  end

  // Quadrature phases hold their level when idle so the drive keeps its count
  always_ff @(posedge sys_clk_in)
  begin
    if (!reset_n_in)
    begin
      fwd_out <= 1'b0;
      rev_out <= 1'b0;
    end
    else
    begin
      case (mode_in)
        PM_CW_CCW:
        begin
          fwd_out <= ph_q && dir_in;
          rev_out <= ph_q && !dir_in;
        end
        PM_PULSE_SIGN:
        begin
          fwd_out <= ph_q;
          rev_out <= run_in && !dir_in;
        end
        default:
        begin
          fwd_out <= quad_q[1];
          rev_out <= quad_q[1] ^ quad_q[0];
        end
      endcase
    end
  end

endmodule

`default_nettype wire

// ### rtl/axs_top.sv
// Two-axis positioning I/O: input sampling, axis control, pulse and clear outputs
//
// Implementation choices: strobed register access and the register offsets.
`timescale 1ns/10ps
`default_nettype none
`include "axs_defines.svh"

// Behaviour
// - Leading edge of origin zero input marks the origin during origin return.
// - In stopper method, a zero input leading edge completes origin return.
// - Switch input edge moves speed/position operation from speed to position.
// - Drive not ready sets the origin return request flag.
// - Ready loss stops the axis; it stays stopped until a new start.
// - Ready loss clears the origin return done flag.
// - Unselected ready and limit inputs are taken as permanently asserted.
// - Either stroke limit going low stops positioning.
// - With retry, limits bound the near-point search and reverse travel.
// - Near-point input is detected on its leading edge during origin return.
// - Droop clear output is high during origin return except count 2 method.
// - Pulses leave on forward and reverse outputs in the selected encoding.
// - Four pulse encodings exist; CW/CCW is the reset default.
module axs_top
  import axs_pkg::*;
(
  input wire logic sys_clk_in,
  input wire logic reset_n_in,
  input wire logic [`AXS_AW-1:0] reg_addr_in,
  input wire logic [`AXS_DW-1:0] reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  output logic [`AXS_DW-1:0] reg_rdata_out,
  input wire axs_pkg::axs_pins_s [`AXS_N-1:0] axis_pins_in,
  output logic [`AXS_N-1:0] pulse_fwd_out,
  output logic [`AXS_N-1:0] pulse_rev_out,
  output logic [`AXS_N-1:0] droop_clear_out,
  output logic irq_out
);

  logic [`AXS_N*`AXS_PINS_W-1:0] sync_lvl;
  logic [`AXS_N*`AXS_PINS_W-1:0] sync_rise;
  logic [`AXS_IRQ_W-1:0] evt_all;
  logic [`AXS_DW-1:0] rd_cfg [`AXS_N];
  logic [`AXS_DW-1:0] rd_cnt [`AXS_N];
  logic [`AXS_DW-1:0] rd_half [`AXS_N];
  logic [`AXS_DW-1:0] rd_stat [`AXS_N];
  logic [`AXS_IRQ_W-1:0] irq_stat_q;
  logic [`AXS_IRQ_W-1:0] irq_en_q;
  logic [`AXS_IRQ_W-1:0] irq_stat_d;
  logic [`AXS_IRQ_W-1:0] irq_en_d;
  logic [`AXS_IRQ_W-1:0] irq_clr;
  logic [`AXS_DW-1:0] rdata_d;

  // An input whose function is not selected reads as asserted
  function automatic logic eff_level(input logic used, input logic raw);
    eff_level = raw || !used;
  endfunction

  function automatic logic reg_hit(
    input logic [`AXS_AW-1:0] addr,
    input int axis,
    input logic [`AXS_AW-1:0] off
  );
    reg_hit = (addr == (`AXS_AW'(axis * `AXS_STRIDE) + off));
  endfunction

  axs_in_sync #(
    .W(`AXS_N*`AXS_PINS_W)
  ) u_sync (
    .sys_clk_in(sys_clk_in),
    .reset_n_in(reset_n_in),
    .raw_in(axis_pins_in),
    .lvl_out(sync_lvl),
    .rise_out(sync_rise)
  );

  genvar a;
  generate
    for (a = 0; a < `AXS_N; a++)
    begin : g_axis
      axs_cfg_s cfg_q;
      axs_state_e st_q;
      axs_pins_s lvl;
      axs_pins_s rise;
      logic [`AXS_DW-1:0] cnt_q;
      logic [`AXS_DW-1:0] half_q;
      logic [`AXS_DW-1:0] left_q;
      logic dir_q;
      logic done_q;
      logic req_q;
      logic rdy_err_q;
      logic lim_err_q;
      logic clr_q;
      logic rdy;
      logic up;
      logic lo;
      logic moving;
      logic step;
      logic at_lim;
      logic halt_rdy;
      logic halt_lim;
      logic halted;
      logic opr_end;
      logic pos_end;
      logic wr_cmd;
      logic start_opr;
      logic start_pos;
      logic start_spd;
      logic stop_cmd;
      logic go;
      logic [`AXS_DW-1:0] stat;

      assign lvl = sync_lvl[a*`AXS_PINS_W +: `AXS_PINS_W];
      assign rise = sync_rise[a*`AXS_PINS_W +: `AXS_PINS_W];

      assign rdy = eff_level(cfg_q.ready_sel, lvl.drive_ready_input);
      assign up = eff_level(cfg_q.ulim_sel, lvl.upper_stroke_limit_input);
      assign lo = eff_level(cfg_q.llim_sel, lvl.lower_stroke_limit_input);

      assign moving = (st_q != ST_IDLE);
      assign wr_cmd = reg_wr_in && reg_hit(reg_addr_in, a, `AXS_OFF_CMD);
      assign start_opr = wr_cmd && reg_wdata_in[`AXS_CMD_OPR];
      assign start_pos = wr_cmd && reg_wdata_in[`AXS_CMD_POS];
      assign start_spd = wr_cmd && reg_wdata_in[`AXS_CMD_SPD];
      assign stop_cmd = wr_cmd && reg_wdata_in[`AXS_CMD_STOP];
      // A start is refused while the drive is not ready
      assign go = (st_q == ST_IDLE) && rdy && (start_opr || start_pos || start_spd);

      // Travel is heading into the limit that is open
      assign at_lim = (!up && dir_q) || (!lo && !dir_q);
      assign halt_rdy = moving && !rdy;
      assign halt_lim = moving && !halt_rdy && (!up || !lo)
        && !(st_q == ST_DOG && cfg_q.retry_en);
      assign halted = halt_rdy || halt_lim || (moving && stop_cmd);
      assign opr_end = !halted && rise.origin_zero_input
        && ((st_q == ST_DOG && cfg_q.method == OM_STOPPER)
        || st_q == ST_ZERO);
      assign pos_end = !halted && (st_q == ST_POS) && step && (left_q == `AXS_ONE);

      always_ff @(posedge sys_clk_in)
      begin
        if (!reset_n_in)
        begin
          cfg_q <= axs_cfg_s'(`AXS_CFG_RST);
          cnt_q <= `AXS_CNT_RST;
          half_q <= `AXS_HALF_RST;
        end
        else if (reg_wr_in)
        begin
          if (reg_hit(reg_addr_in, a, `AXS_OFF_CFG))
            cfg_q <= axs_cfg_s'(reg_wdata_in[`AXS_CFG_W-1:0]);
          if (reg_hit(reg_addr_in, a, `AXS_OFF_CNT))
            cnt_q <= reg_wdata_in;
          if (reg_hit(reg_addr_in, a, `AXS_OFF_HALF))
            half_q <= reg_wdata_in;
        end
      end

      always_ff @(posedge sys_clk_in)
      begin
        if (!reset_n_in)
        begin
          st_q <= ST_IDLE;
          dir_q <= 1'b0;
          left_q <= '0;
        end
        else if (halted)
          st_q <= ST_IDLE;
        else
        begin
          case (st_q)
            ST_IDLE:
            begin
              if (go)
              begin
                dir_q <= reg_wdata_in[`AXS_CMD_DIR];
                left_q <= cnt_q;
                if (start_opr)
                  st_q <= ST_DOG;
                else if (start_pos && cnt_q != '0)
                  st_q <= ST_POS;
                else if (start_spd)
                  st_q <= ST_SPD;
              end
            end
            ST_POS:
            begin
              if (step)
                left_q <= left_q - `AXS_ONE;
              if (pos_end)
                st_q <= ST_IDLE;
            end
            ST_SPD:
            begin
              if (rise.speed_to_position_switch_input)
              begin
                left_q <= cnt_q;
                st_q <= (cnt_q == '0) ? ST_IDLE : ST_POS;
              end
            end
            ST_DOG:
            begin
              if (cfg_q.retry_en && at_lim)
                dir_q <= ~dir_q;
              if (opr_end)
                st_q <= ST_IDLE;
              else if (rise.near_point_input)
                st_q <= ST_ZERO;
            end
            ST_ZERO:
            begin
              if (opr_end)
                st_q <= ST_IDLE;
            end
            default: st_q <= ST_IDLE;
          endcase
        end
      end

      // Drive not ready wins over the end of origin return in the same cycle
      always_ff @(posedge sys_clk_in)
      begin
        if (!reset_n_in)
        begin
          req_q <= 1'b1;
          done_q <= 1'b0;
        end
        else
        begin
          if (!rdy)
            req_q <= 1'b1;
          else if (opr_end)
            req_q <= 1'b0;
          if (!rdy)
            done_q <= 1'b0;
          else if (opr_end)
            done_q <= 1'b1;
          else if (go && start_opr)
            done_q <= 1'b0;
        end
      end

      always_ff @(posedge sys_clk_in)
      begin
        if (!reset_n_in)
        begin
          rdy_err_q <= 1'b0;
          lim_err_q <= 1'b0;
        end
        else
        begin
          if (halt_rdy)
            rdy_err_q <= 1'b1;
          else if (go)
            rdy_err_q <= 1'b0;
          if (halt_lim)
            lim_err_q <= 1'b1;
          else if (go)
            lim_err_q <= 1'b0;
        end
      end

      // Count 2 keeps the deviation counter running through the return
      always_ff @(posedge sys_clk_in)
      begin
        if (!reset_n_in)
          clr_q <= 1'b0;
        else
          clr_q <= (st_q == ST_DOG || st_q == ST_ZERO)
            && cfg_q.method != OM_COUNT2;
      end

      axs_pulse_gen u_pulse (
        .sys_clk_in(sys_clk_in),
        .reset_n_in(reset_n_in),
        .run_in(moving),
        .dir_in(dir_q),
        .mode_in(cfg_q.mode),
        .half_in(half_q),
        .fwd_out(pulse_fwd_out[a]),
        .rev_out(pulse_rev_out[a]),
        .step_out(step)
      );

      assign droop_clear_out[a] = clr_q;

      always_comb
      begin
        stat = '0;
        stat[`AXS_ST_BUSY] = moving;
        stat[`AXS_ST_DONE] = done_q;
        stat[`AXS_ST_REQ] = req_q;
        stat[`AXS_ST_RDY_ERR] = rdy_err_q;
        stat[`AXS_ST_LIM_ERR] = lim_err_q;
        stat[`AXS_ST_STATE +: `AXS_ST_STATE_W] = st_q;
        stat[`AXS_ST_PINS +: `AXS_PINS_W] = lvl;
      end

      assign rd_cfg[a] = {{(`AXS_DW-`AXS_CFG_W){1'b0}}, cfg_q};
      assign rd_cnt[a] = cnt_q;
      assign rd_half[a] = half_q;
      assign rd_stat[a] = stat;
      assign evt_all[a*`AXS_EVT_W + `AXS_EVT_OPR] = opr_end;
      assign evt_all[a*`AXS_EVT_W + `AXS_EVT_RDY] = halt_rdy;
      assign evt_all[a*`AXS_EVT_W + `AXS_EVT_LIM] = halt_lim;
      assign evt_all[a*`AXS_EVT_W + `AXS_EVT_POS] = pos_end;
    end
  endgenerate

  // Sticky events: a new event outranks a clear written in the same cycle
  always_comb
  begin
    irq_clr = '0;
    irq_en_d = irq_en_q;
    if (reg_wr_in && reg_addr_in == `AXS_IRQ_CLR)
      irq_clr = reg_wdata_in[`AXS_IRQ_W-1:0];
    if (reg_wr_in && reg_addr_in == `AXS_IRQ_EN)
      irq_en_d = reg_wdata_in[`AXS_IRQ_W-1:0];
    irq_stat_d = (irq_stat_q & ~irq_clr) | evt_all;
  end

  always_ff @(posedge sys_clk_in)
  begin
    if (!reset_n_in)
    begin
      irq_stat_q <= '0;
      irq_en_q <= '0;
      irq_out <= 1'b0;
    end
    else
    begin
      irq_stat_q <= irq_stat_d;
      irq_en_q <= irq_en_d;
      irq_out <= |(irq_stat_d & irq_en_d);
    end
  end

  always_comb
  begin
    rdata_d = '0;
    for (int i = 0; i < `AXS_N; i++)
    begin
      if (reg_hit(reg_addr_in, i, `AXS_OFF_CFG))
        rdata_d = rd_cfg[i];
      if (reg_hit(reg_addr_in, i, `AXS_OFF_CNT))
        rdata_d = rd_cnt[i];
      if (reg_hit(reg_addr_in, i, `AXS_OFF_HALF))
        rdata_d = rd_half[i];
      if (reg_hit(reg_addr_in, i, `AXS_OFF_STAT))
        rdata_d = rd_stat[i];
    end
    if (reg_addr_in == `AXS_IRQ_STAT)
      rdata_d = {{(`AXS_DW-`AXS_IRQ_W){1'b0}}, irq_stat_q};
    if (reg_addr_in == `AXS_IRQ_EN)
      rdata_d = {{(`AXS_DW-`AXS_IRQ_W){1'b0}}, irq_en_q};
  end

  // Read data stand only in the cycle after the strobe
  always_ff @(posedge sys_clk_in)
  begin
    if (!reset_n_in || !reg_rd_in)
      reg_rdata_out <= '0;
    else
      reg_rdata_out <= rdata_d;
  end

endmodule

`default_nettype wire

// ### dv/axs_top_assertions.sv
// Port-level checker for the two-axis positioning I/O block
`timescale 1ns/10ps
`default_nettype none
`include "axs_defines.svh"
module axs_top_checker
  import axs_pkg::*;
(
  input wire logic sys_clk_in,
  input wire logic reset_n_in,
  input wire logic [`AXS_AW-1:0] reg_addr_in,
  input wire logic [`AXS_DW-1:0] reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  input wire logic [`AXS_DW-1:0] reg_rdata_out,
  input wire axs_pkg::axs_pins_s [`AXS_N-1:0] axis_pins_in,
  input wire logic [`AXS_N-1:0] pulse_fwd_out,
  input wire logic [`AXS_N-1:0] pulse_rev_out,
  input wire logic [`AXS_N-1:0] droop_clear_out,
  input wire logic irq_out
);
  logic [7:0] cfg_q;
  logic [7:0] en_q;
  logic rd_stat;
  default clocking @(posedge sys_clk_in); endclocking
  default disable iff (!reset_n_in);
  assign rd_stat = reg_rd_in && reg_addr_in == `AXS_OFF_STAT;
  // Shadows rebuilt from bus writes, so only axis 0 is watched
  always_ff @(posedge sys_clk_in)
  begin
    if (!reset_n_in)
    begin
      cfg_q <= 8'h00;
      en_q <= 8'h00;
    end
    else if (reg_wr_in)
    begin
      if (reg_addr_in == `AXS_OFF_CFG) cfg_q <= reg_wdata_in[7:0];
      if (reg_addr_in == `AXS_IRQ_EN) en_q <= reg_wdata_in[7:0];
    end
  end
  // Four cycles cover the two sync flops; CW/CCW idles with both outputs low
  sequence rdy_lost;
    (cfg_q[4] && !axis_pins_in[0].drive_ready_input && cfg_q[1:0] == 2'h0)[*4];
  endsequence
  sequence lim_lost;
    (cfg_q[6] && !cfg_q[7] && !axis_pins_in[0].lower_stroke_limit_input
      && cfg_q[1:0] == 2'h0)[*4];
  endsequence
  a_rdata_idle: assert property (!reg_rd_in |=> reg_rdata_out == 16'h0000)
    else $error("read data not zero outside its slot");
  a_reset_quiet: assert property ($rose(reset_n_in) |-> pulse_fwd_out == 2'h0
    && pulse_rev_out == 2'h0 && droop_clear_out == 2'h0 && !irq_out)
    else $error("outputs active right after reset");
  a_ready_halt: assert property (rdy_lost |-> ##2 !pulse_fwd_out[0] && !pulse_rev_out[0])
    else $error("pulses continue without drive ready");
  a_limit_halt: assert property (lim_lost |-> ##2 !pulse_fwd_out[0] && !pulse_rev_out[0])
    else $error("pulses continue with limit open");
  a_count2_noclr: assert property ((cfg_q[3:2] == 2'h3)[*2] |-> !droop_clear_out[0])
    else $error("droop clear raised in count 2 method");
  a_irq_masked: assert property ((en_q == 8'h00)[*2] |-> !irq_out)
    else $error("interrupt raised with all sources masked");
  a_stat_ready: assert property ((cfg_q[4] && !axis_pins_in[0].drive_ready_input)[*4]
    ##0 rd_stat |=> reg_rdata_out[`AXS_ST_REQ] && !reg_rdata_out[`AXS_ST_DONE])
    else $error("status flags wrong while drive not ready");
  a_cw_excl: assert property ((cfg_q[1:0] == 2'h0)[*4] |-> !(pulse_fwd_out[0]
    && pulse_rev_out[0]))
    else $error("both CW and CCW outputs high");
endmodule
bind axs_top axs_top_checker chk_u (.sys_clk_in, .reset_n_in, .reg_addr_in, .reg_wdata_in,
  .reg_wr_in, .reg_rd_in, .reg_rdata_out, .axis_pins_in, .pulse_fwd_out, .pulse_rev_out,
  .droop_clear_out, .irq_out);
`default_nettype wire

// ### dv/axs_drive_model.sv
// Behavioural drive unit and machine switches for one axis
`timescale 1ns/10ps
`default_nettype none
module axs_drive_model
  import axs_pkg::*;
(
  input wire logic sys_clk_in,
  input wire logic rst_n_in,
  input wire logic pulse_fwd_in,
  input wire logic pulse_rev_in,
  input wire logic droop_clear_in,
  input wire logic fault_in,
  input wire logic chg_in,
  input wire logic lim_open_in,
  output axs_pkg::axs_pins_s pins_out,
  output logic [15:0] dev_out
);
  logic fwd_q;
  logic rev_q;
  logic [15:0] pos_q;
  always_ff @(posedge sys_clk_in)
  begin
    fwd_q <= pulse_fwd_in;
    rev_q <= pulse_rev_in;
    if (!rst_n_in)
    begin
      pos_q <= 16'h0000;
      dev_out <= 16'h0000;
    end
    else
    begin
      if (pulse_fwd_in && !fwd_q) pos_q <= pos_q + 16'h0001;
      else if (pulse_rev_in && !rev_q) pos_q <= pos_q - 16'h0001;
      if (droop_clear_in) dev_out <= 16'h0000;
      else if (pulse_fwd_in != fwd_q) dev_out <= dev_out + 16'h0001;
    end
  end
  // Layout repeats every 64 pulses so each origin search meets fresh edges
  always_comb
  begin
    pins_out.origin_zero_input = pos_q[2:0] == 3'h0;
    pins_out.speed_to_position_switch_input = chg_in;
    pins_out.drive_ready_input = !fault_in;
    pins_out.near_point_input = pos_q[5:4] == 2'h3;
    pins_out.upper_stroke_limit_input = 1'b1;
    pins_out.lower_stroke_limit_input = !lim_open_in;
  end
endmodule
`default_nettype wire

// ### dv/axis_positioning_io_tb_top.sv
// Self-checking bench for the two-axis positioning I/O block
`timescale 1ns/10ps
`default_nettype none
`include "axs_defines.svh"
`define CHK(nm, ex, got) \
  begin \
    num_checks++; \
    if ((got) !== (ex)) \
    begin \
      n_fail++; \
      $display("unexpected %s: expected %0h seen %0h", nm, ex, got); \
    end \
  end
module axis_positioning_io_tb_top;
  import axs_pkg::*;
  logic sys_clk_in = 1'b0;
  logic reset_n_in = 1'b0;
  logic [5:0] addr = 6'h00;
  logic [15:0] wdata = 16'h0000;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [15:0] rdata;
  axs_pins_s [1:0] pins;
  axs_pins_s pins0;
  axs_pins_s pins1 = 6'h00;
  logic [1:0] pf;
  logic [1:0] pr;
  logic [1:0] dc;
  logic irq;
  logic fault = 1'b0;
  logic chg = 1'b0;
  logic lim_open = 1'b0;
  logic fwd_q = 1'b0;
  logic rev_q = 1'b0;
  logic [15:0] d;
  int e_fwd = 0;
  int e_rev = 0;
  int n_dc = 0;
  int b_fwd;
  int b_rev;
  int b_dc;
  int c;
  int n_fail = 0;
  int num_checks = 0;
  int cycles = 0;
  assign pins = {pins1, pins0};
  axs_top dut_u (.sys_clk_in, .reset_n_in, .reg_addr_in(addr), .reg_wdata_in(wdata),
    .reg_wr_in(wr), .reg_rd_in(rd), .reg_rdata_out(rdata), .axis_pins_in(pins),
    .pulse_fwd_out(pf), .pulse_rev_out(pr), .droop_clear_out(dc), .irq_out(irq));
  axs_drive_model drv_u (.sys_clk_in, .rst_n_in(reset_n_in), .pulse_fwd_in(pf[0]),
    .pulse_rev_in(pr[0]), .droop_clear_in(dc[0]), .fault_in(fault), .chg_in(chg),
    .lim_open_in(lim_open), .pins_out(pins0), .dev_out());
  initial forever #5 sys_clk_in = ~sys_clk_in;
  // Edge counters only grow; scenarios compare against snapshots to avoid races
  always @(posedge sys_clk_in)
  begin
    fwd_q <= pf[0];
    rev_q <= pr[0];
    if (pf[0] !== fwd_q) e_fwd <= e_fwd + 1;
    if (pr[0] !== rev_q) e_rev <= e_rev + 1;
    if (dc[0] === 1'b1) n_dc <= n_dc + 1;
    pins1 <= axs_pins_s'(6'($urandom));
    cycles++;
    if (cycles == 60000)
    begin
      n_fail++;
      complete_run();
    end
  end
  function automatic int exp_edges(input logic [1:0] m, input int n);
    case (m)
      2'h2: return 4 * n;
      2'h3: return n;
      default: return 2 * n;
    endcase
  endfunction
  task automatic wr_reg(input logic [5:0] a, input logic [15:0] v);
    @(posedge sys_clk_in);
    addr <= a;
    wdata <= v;
    wr <= 1'b1;
    @(posedge sys_clk_in);
    wr <= 1'b0;
  endtask
  task automatic rd_reg(input logic [5:0] a, output logic [15:0] v);
    @(posedge sys_clk_in);
    addr <= a;
    rd <= 1'b1;
    @(posedge sys_clk_in);
    rd <= 1'b0;
    #1 v = rdata;
  endtask
  task automatic chk_reg(input logic [5:0] a, input logic [15:0] ex, input string nm);
    logic [15:0] v;
    rd_reg(a, v);
    `CHK(nm, ex, v)
  endtask
  task automatic move(input logic [7:0] cfg, input logic [15:0] n, input logic [7:0] cmd);
    wr_reg(`AXS_OFF_CFG, {8'h00, cfg});
    wr_reg(`AXS_OFF_CNT, n);
    wr_reg(`AXS_IRQ_CLR, 16'h00FF);
    b_fwd = e_fwd;
    b_rev = e_rev;
    b_dc = n_dc;
    wr_reg(`AXS_OFF_CMD, {8'h00, cmd});
  endtask
  task automatic wait_irq(input int lim);
    for (int i = 0; i < lim && irq !== 1'b1; i++)
    begin
      @(posedge sys_clk_in);
      #1;
    end
    `CHK("irq_out", 1'b1, irq)
    repeat (4) @(posedge sys_clk_in);
  endtask
  task automatic complete_run();
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  initial
  begin
    void'($urandom(32'h75F2));
    repeat (16) @(posedge sys_clk_in);
    reset_n_in <= 1'b1;
    chk_reg(`AXS_OFF_CFG, 16'h0000, "cfg0");
    chk_reg(`AXS_OFF_HALF, `AXS_HALF_RST, "half0");
    chk_reg(`AXS_OFF_STAT, 16'h2B04, "stat0");
    wr_reg(6'h3F, 16'hFFFF);
    chk_reg(6'h3F, 16'h0000, "unmapped");
    wr_reg(`AXS_OFF_HALF, 16'h0001);
    wr_reg(`AXS_IRQ_EN, 16'h00FF);
    // Every pulse encoding in both directions
    for (int m = 0; m < 8; m++)
    begin
      c = 1 + $urandom_range(7);
      move(8'h70 | 8'(m % 4), 16'(c), m > 3 ? 8'h0A : 8'h02);
      wait_irq(500);
      if (m % 4 == 1) `CHK("fwd edges", exp_edges(1, c), e_fwd - b_fwd)
      else `CHK("edges", exp_edges(2'(m), c), e_fwd - b_fwd + e_rev - b_rev)
      if (m % 4 == 0) `CHK("idle side", 0, m > 3 ? e_rev - b_rev : e_fwd - b_fwd)
      chk_reg(`AXS_IRQ_STAT, 16'h0008, "irq_stat");
    end
    wr_reg(`AXS_IRQ_EN, 16'h0000);
    move(8'h70, 16'h0002, 8'h0A);
    repeat (40) @(posedge sys_clk_in);
    #1 `CHK("masked irq", 1'b0, irq)
    wr_reg(`AXS_IRQ_EN, 16'h00FF);
    #1 `CHK("unmasked irq", 1'b1, irq)
    // Origin return in all four methods; droop clear absent only for count 2
    for (int k = 0; k < 4; k++)
    begin
      move(8'h10 | 8'(k << 2), 16'h0000, 8'h09);
      wait_irq(2000);
      `CHK("droop seen", k != 3, n_dc != b_dc)
      rd_reg(`AXS_OFF_STAT, d);
      `CHK("origin flags", 3'h2, d[2:0])
    end
    // Retry search heading down meets the open lower limit: travel turns, no halt
    move(8'hD0, 16'h0000, 8'h01);
    repeat (10) @(posedge sys_clk_in);
    lim_open <= 1'b1;
    repeat (8) @(posedge sys_clk_in);
    lim_open <= 1'b0;
    wait_irq(2000);
    `CHK("retry reverse", 1'b1, e_fwd != b_fwd)
    chk_reg(`AXS_IRQ_STAT, 16'h0001, "retry done");
    rd_reg(`AXS_OFF_STAT, d);
    `CHK("retry flags", 5'h02, d[4:0])
    move(8'h70, 16'h00C8, 8'h0A);
    repeat (20) @(posedge sys_clk_in);
    fault <= 1'b1;
    repeat (8) @(posedge sys_clk_in);
    rd_reg(`AXS_OFF_STAT, d);
    `CHK("ready loss stat", 5'h0C, d[4:0])
    fault <= 1'b0;
    b_fwd = e_fwd;
    repeat (30) @(posedge sys_clk_in);
    `CHK("no restart", 0, e_fwd - b_fwd)
    chk_reg(`AXS_IRQ_STAT, 16'h0002, "ready irq");
    fault <= 1'b1;
    move(8'h00, 16'h0003, 8'h0A);
    wait_irq(200);
    `CHK("unselected ready", 6, e_fwd - b_fwd)
    fault <= 1'b0;
    move(8'h70, 16'h00C8, 8'h02);
    repeat (20) @(posedge sys_clk_in);
    lim_open <= 1'b1;
    repeat (8) @(posedge sys_clk_in);
    rd_reg(`AXS_OFF_STAT, d);
    `CHK("limit stop", 1'b1, d[`AXS_ST_LIM_ERR])
    lim_open <= 1'b0;
    move(8'h70, 16'h0005, 8'h0C);
    repeat (40) @(posedge sys_clk_in);
    rd_reg(`AXS_OFF_STAT, d);
    `CHK("speed phase", 3'h2, d[7:5])
    chg <= 1'b1;
    wait_irq(200);
    chg <= 1'b0;
    chk_reg(`AXS_IRQ_STAT, 16'h0008, "switch done");
    complete_run();
  end
endmodule
`default_nettype wire
